// File: rtl/csh_defs.vh
// Constants for the control/signaling change handler
`ifndef CSH_DEFS_VH
`define CSH_DEFS_VH
// Register word indices (byte address = 4 * index)
`define CSH_REG_QUEUE 4'h0
`define CSH_REG_TIMER 4'h1
`define CSH_REG_CMD 4'h2
`define CSH_REG_STATE 4'h3
`define CSH_REG_ISTA 4'h4
`define CSH_REG_MASK 4'h5
`define CSH_REG_LOC 4'h6
`define CSH_REG_VALUE 4'h7
`define CSH_REG_MAC 4'h8
`define CSH_REG_MODE 4'h9
// Field positions
`define CSH_TIMER_RATE 7
`define CSH_CMD_GO 6
`define CSH_CMD_FLUSH 4
`define CSH_INT_QUEUE 6
`define CSH_STATE_RUN 7
`define CSH_STATE_MAC 2
`define CSH_MAC_RDSEL 7
`define CSH_MODE_RUN 0
// Reset values
`define CSH_STATE_RST 8'h05
`define CSH_TIMER_RST 8'h00
// Channel codes and opcodes
`define CSH_CODE_CI 4'h8
`define CSH_CODE_SIGNAL6 4'ha
`define CSH_CODE_SIGNAL8 4'hb
`define CSH_OPC_DATA 4'h9
// Queue
`define CSH_QDEPTH 9
// Timing
`define CSH_CLK_HZ 25000000
`define CSH_TICK_US 250
`define CSH_TICK_CYC ((`CSH_TICK_US * (`CSH_CLK_HZ / 1000)) / 1000)
`endif

// File: rtl/csh_top.v
// Control/signaling change handler with Avalon-MM register slave
//
// Operation
// - Resend downstream value every frame until reloaded
// - Upstream change queues location, raises queue flag
// - Queue holds nine entries, memory updated
// - Beyond nine, changes stay pending, not lost
// - Only coded slots are processed as channels
// - Queue word: valid bit seven, location below
// - Command channels even location, signaling odd
// - Rate select one: sample every frame
// - Rate select zero: timer period sampling
// - Timer starts on go, stops on setup writes or mode low
// - One timer serves both the expiry output and sampling
// - Flush command clears queue and flag
// - Command bit one starts, zero ignored
// - State register live, resets to 05
// - Queue flag follows non-empty queue only
// - Mask gates only the interrupt pin
// - Opcode 111X writes code and data
// - Opcode 1001 writes data field only
// - Signaling sample stored as actual value
// - Stable updated after two equal differing samples
//
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "csh_defs.vh"

module csh_top #(
   parameter TICK_CYC = `CSH_TICK_CYC
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire frame_pulse,
   input wire slot_strobe,
   input wire [6:0] slot_index,
   input wire [7:0] rx_data,
   output reg [7:0] tx_data,
   output reg tx_valid,
   output wire timer_expired,
   output wire irq_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Storage
   reg [3:0] code_mem [0:255];
   reg [7:0] even_mem [0:127];
   reg [7:0] odd_mem [0:127];
   reg [6:0] q_mem [0:8];
   reg [3:0] q_wr_reg;
   reg [3:0] q_rd_reg;
   reg [3:0] q_cnt_reg;
   reg [7:0] timer_setup_reg;
   reg [7:0] mask_reg;
   reg [7:0] loc_reg;
   reg [7:0] value_reg;
   reg [7:0] mac_reg;
   reg mode_run_reg;
   reg timer_run_reg;
   reg [14:0] tick_cnt_reg;
   reg [6:0] per_cnt_reg;
   reg tick_pend_reg;
   reg sample_frame_reg;
   reg mac_busy_reg;
   reg rd_done_reg;

   wire wr_req;
   wire rd_req;
   wire mac_wr;
   wire q_pop;
   wire q_flush;
   wire q_full;
   wire queue_flag;
   wire [7:0] state_val;
   wire [7:0] ista_val;
   wire [7:0] q_word;
   wire tick_end;
   wire [7:0] up_even;
   wire [7:0] up_odd;
   wire [6:0] up_idx;
   wire [3:0] up_code;
   wire up_slot;
   wire is_ci;
   wire is_signal;
   wire ci_change;
   wire signal_change;
   wire mac_go;
   wire do_push;
   wire [6:0] push_loc;
   wire [7:0] mem_idx;
   wire [6:0] ds_idx;
   wire [3:0] ds_code;
   reg [7:0] rd_mux;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus handshake
   // Reads take one wait cycle so the queue pop lines up with the captured word
   assign rd_req = avs_read & ~rd_done_reg;
   assign mac_wr = avs_write & avs_byteenable[0] & (avs_address == `CSH_REG_MAC);
   // Memory op stalls while a serial slot owns the memory this cycle
   assign avs_waitrequest = rd_req | (mac_wr & slot_strobe);
   assign wr_req = avs_write & ~avs_waitrequest & avs_byteenable[0];

   // Read completion flag
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_done_reg <= 1'b0;
      end else begin
         rd_done_reg <= rd_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Queue word and status values
   // Valid flag above location
   assign q_word = (q_cnt_reg != 4'h0) ? {1'b1, q_mem[q_rd_reg]} : 8'h00;
   // Pop only when an entry exists
   assign q_pop = rd_req & (avs_address == `CSH_REG_QUEUE) & (q_cnt_reg != 4'h0);
   // Only ones in the command start operations
   assign q_flush = wr_req & (avs_address == `CSH_REG_CMD) & avs_writedata[`CSH_CMD_FLUSH];
   assign q_full = (q_cnt_reg == `CSH_QDEPTH);
   // Flag is the live non-empty state
   assign queue_flag = (q_cnt_reg != 4'h0);
   assign ista_val = {1'b0, queue_flag, 6'h00};
   // Live state; feature-handler empty bit fixed high since that handler is outside
   assign state_val = {timer_run_reg, 4'h0, mac_busy_reg, 1'b0, 1'b1};
   assign irq_out = queue_flag & ~mask_reg[`CSH_INT_QUEUE];

   // Read data selection
   always @* begin
      case (avs_address)
         `CSH_REG_QUEUE: rd_mux = q_word;
         `CSH_REG_STATE: rd_mux = state_val;
         `CSH_REG_ISTA: rd_mux = ista_val;
         `CSH_REG_MASK: rd_mux = mask_reg;
         `CSH_REG_LOC: rd_mux = loc_reg;
         `CSH_REG_VALUE: rd_mux = value_reg;
         `CSH_REG_MAC: rd_mux = mac_reg;
         `CSH_REG_MODE: rd_mux = {7'h00, mode_run_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   // Read data register; write-only and unmapped words read zero
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         avs_readdata <= 32'h00000000;
      end else if (rd_req) begin
         avs_readdata <= {24'h000000, rd_mux};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Plain control registers
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_setup_reg <= `CSH_TIMER_RST;
         mask_reg <= 8'h00;
         loc_reg <= 8'h00;
         mac_reg <= 8'h00;
         mode_run_reg <= 1'b0;
      end else if (wr_req) begin
         case (avs_address)
            `CSH_REG_TIMER: timer_setup_reg <= avs_writedata[7:0];
            `CSH_REG_MASK: mask_reg <= avs_writedata[7:0];
            `CSH_REG_LOC: loc_reg <= avs_writedata[7:0];
            `CSH_REG_MAC: mac_reg <= avs_writedata[7:0];
            `CSH_REG_MODE: mode_run_reg <= avs_writedata[`CSH_MODE_RUN];
            default: mode_run_reg <= mode_run_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Timer
   // Period is (1 + value) base ticks
   assign tick_end = timer_run_reg & (tick_cnt_reg == TICK_CYC - 1)
      & (per_cnt_reg == timer_setup_reg[6:0]);
   // Same expiry feeds the timer_expired output and the frame sampling
   assign timer_expired = tick_end;

   // Go starts, setup write or mode bit low stops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_run_reg <= 1'b0;
         tick_cnt_reg <= 15'h0000;
         per_cnt_reg <= 7'h00;
      end else if ((wr_req & (avs_address == `CSH_REG_TIMER)) | ~mode_run_reg) begin
         timer_run_reg <= 1'b0;
         tick_cnt_reg <= 15'h0000;
         per_cnt_reg <= 7'h00;
      end else if (wr_req & (avs_address == `CSH_REG_CMD) & avs_writedata[`CSH_CMD_GO]) begin
         timer_run_reg <= 1'b1;
         tick_cnt_reg <= 15'h0000;
         per_cnt_reg <= 7'h00;
      end else if (timer_run_reg) begin
         if (tick_cnt_reg == TICK_CYC - 1) begin
            tick_cnt_reg <= 15'h0000;
            per_cnt_reg <= tick_end ? 7'h00 : per_cnt_reg + 7'h01;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 15'h0001;
         end
      end
   end

   // Rate select one samples every frame, timer untouched
   // Expiry is held until the next frame so sampling always covers a whole frame
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tick_pend_reg <= 1'b0;
         sample_frame_reg <= 1'b0;
      end else if (frame_pulse) begin
         sample_frame_reg <= timer_setup_reg[`CSH_TIMER_RATE] | tick_pend_reg | tick_end;
         tick_pend_reg <= 1'b0;
      end else if (tick_end) begin
         tick_pend_reg <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Upstream change detection
   assign up_slot = slot_strobe & slot_index[0] & mode_run_reg;
   assign up_idx = {1'b1, slot_index[6:1]};
   assign up_code = code_mem[{1'b1, slot_index}];
   assign up_even = even_mem[up_idx];
   assign up_odd = odd_mem[up_idx];
   // Only coded slot pairs are handled
   assign is_ci = up_slot & (up_code == `CSH_CODE_CI);
   assign is_signal = up_slot & sample_frame_reg
      & ((up_code == `CSH_CODE_SIGNAL6) | (up_code == `CSH_CODE_SIGNAL8));
   // Command value differs from stored one
   assign ci_change = is_ci & (rx_data != up_even);
   // Second equal sample differing from stable value
   assign signal_change = is_signal & (rx_data == up_even) & (rx_data != up_odd);
   // Full queue or a flush leaves the change pending, so none is lost
   assign do_push = (ci_change | signal_change) & ~q_full & ~q_flush;
   // Even location for commands, odd for signaling
   assign push_loc = {slot_index[6:1], signal_change};

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         q_wr_reg <= 4'h0;
         q_rd_reg <= 4'h0;
         q_cnt_reg <= 4'h0;
      end else if (q_flush) begin
         // Flush clears entries and flag at once
         q_wr_reg <= 4'h0;
         q_rd_reg <= 4'h0;
         q_cnt_reg <= 4'h0;
      end else begin
         if (do_push) begin
            q_wr_reg <= (q_wr_reg == `CSH_QDEPTH - 1) ? 4'h0 : q_wr_reg + 4'h1;
         end
         if (q_pop) begin
            q_rd_reg <= (q_rd_reg == `CSH_QDEPTH - 1) ? 4'h0 : q_rd_reg + 4'h1;
         end
         q_cnt_reg <= q_cnt_reg + {3'h0, do_push} - {3'h0, q_pop};
      end
   end

   // Queue entry storage
   always @(posedge ref_clk) begin
      if (do_push & ~q_flush) begin
         q_mem[q_wr_reg] <= push_loc;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Control memory write ports
   // Software and serial slots never write in the same cycle
   assign mem_idx = loc_reg;
   // Opcode qualifies the access; it runs at the accepting edge
   // the only cycle the strobe stall keeps free of serial writes
   assign mac_go = wr_req & (avs_address == `CSH_REG_MAC)
      & ((avs_writedata[6:4] == 3'h7) | (avs_writedata[6:3] == `CSH_OPC_DATA));

   // Even data field
   always @(posedge ref_clk) begin
      if (do_push & ci_change) begin
         even_mem[up_idx] <= rx_data;
      end else if (is_signal) begin
         // Every sample kept as actual value
         even_mem[up_idx] <= rx_data;
      end else if (mac_go & ~avs_writedata[`CSH_MAC_RDSEL] & ~mem_idx[0]) begin
         even_mem[{mem_idx[7], mem_idx[6:1]}] <= value_reg;
      end
   end

   // Odd data field
   always @(posedge ref_clk) begin
      if (do_push & signal_change) begin
         odd_mem[up_idx] <= rx_data;
      end else if (mac_go & ~avs_writedata[`CSH_MAC_RDSEL] & mem_idx[0]) begin
         odd_mem[{mem_idx[7], mem_idx[6:1]}] <= value_reg;
      end
   end

   // Code field written by the code-and-data opcode
   always @(posedge ref_clk) begin
      if (mac_go & ~avs_writedata[`CSH_MAC_RDSEL] & (avs_writedata[6:4] == 3'h7)) begin
         code_mem[mem_idx] <= avs_writedata[3:0];
      end
   end

   // Busy flag resets high so the state register shows 05 in reset and 01 from the first clock after
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mac_busy_reg <= 1'b1;
         value_reg <= 8'h00;
      end else begin
         mac_busy_reg <= mac_go;
         if (wr_req & (avs_address == `CSH_REG_VALUE)) begin
            value_reg <= avs_writedata[7:0];
         end else if (mac_go & avs_writedata[`CSH_MAC_RDSEL]
            & (avs_writedata[6:3] == `CSH_OPC_DATA)) begin
            value_reg <= mem_idx[0] ? odd_mem[{mem_idx[7], mem_idx[6:1]}]
               : even_mem[{mem_idx[7], mem_idx[6:1]}];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Downstream transmit
   assign ds_idx = {1'b0, slot_index[6:1]};
   assign ds_code = code_mem[{1'b0, slot_index[6:1], 1'b0}];

   // Even downstream value resent in each odd slot whose even code is a channel code
   // Value taken from the even location
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_data <= 8'hff;
         tx_valid <= 1'b0;
      end else if (slot_strobe & slot_index[0]) begin
         tx_valid <= (ds_code == `CSH_CODE_CI) | (ds_code == `CSH_CODE_SIGNAL6)
            | (ds_code == `CSH_CODE_SIGNAL8);
         tx_data <= even_mem[ds_idx];
      end else begin
         tx_valid <= 1'b0;
      end
   end

endmodule // csh_top

// File: dv/csh_chk.sv
// Port checker for the control/signaling change handler
`timescale 1ns/1ps
module csh_chk #(
   parameter TICK_CYC = 10
) (
   input wire ref_clk,
   input wire rst_n,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire frame_pulse,
   input wire slot_strobe,
   input wire [6:0] slot_index,
   input wire [7:0] rx_data,
   input wire [7:0] tx_data,
   input wire tx_valid,
   input wire timer_expired,
   input wire irq_out
);
   reg [15:0] gap_reg;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////
   // Cycles since last expiry; saturates so long idle spans stay legal
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_reg <= 16'(TICK_CYC);
      end else if (timer_expired) begin
         gap_reg <= 16'h1;
      end else if (gap_reg != 16'hffff) begin
         gap_reg <= gap_reg + 16'h1;
      end
   end
   ////////////////////////////////////////////////////////////////
   a_rd_first: assert property ($rose(avs_read) |-> avs_waitrequest)
      else $error("read not stalled in first cycle");
   a_rd_one: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("read stalled more than one cycle");
   a_wr_fast: assert property (avs_write && avs_address != 4'h8 |-> !avs_waitrequest)
      else $error("plain write stalled");
   a_mac_stall: assert property (avs_write && avs_address == 4'h8 && slot_strobe |-> avs_waitrequest)
      else $error("access write taken during slot strobe");
   a_rd_hold: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   a_tx_after: assert property (tx_valid |-> $past(slot_strobe) && $past(slot_index[0]))
      else $error("downstream pulse without odd slot");
   a_tx_hold: assert property (!$past(slot_strobe) |-> $stable(tx_data))
      else $error("downstream value moved outside a slot");
   a_irq_cause: assert property ($rose(irq_out) |-> $past(slot_strobe) || $past(avs_write))
      else $error("interrupt rose without a change");
   a_flush_clear: assert property (avs_write && !avs_waitrequest && avs_address == 4'h2
      && avs_writedata[4] && avs_byteenable[0] |-> ##[1:2] !irq_out)
      else $error("flush left interrupt up");
   a_timer_gap: assert property (timer_expired |-> gap_reg >= TICK_CYC)
      else $error("timer period too short");
   c_tx: cover property (tx_valid);
   c_irq: cover property ($rose(irq_out));
   c_timer: cover property (timer_expired);
endmodule // csh_chk

bind csh_top csh_chk #(.TICK_CYC(TICK_CYC)) u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .frame_pulse(frame_pulse), .slot_strobe(slot_strobe), .slot_index(slot_index),
   .rx_data(rx_data), .tx_data(tx_data), .tx_valid(tx_valid),
   .timer_expired(timer_expired), .irq_out(irq_out));

// File: dv/csh_sub_model.sv
// Subscriber-side model: frame timing, upstream values, downstream capture
`timescale 1ns/1ps
module csh_sub_model #(
   parameter FRAME_CYC = 200
) (
   input wire ref_clk,
   input wire rst_n,
   output reg frame_pulse,
   output reg slot_strobe,
   output reg [6:0] slot_index,
   output reg [7:0] rx_data,
   input wire [7:0] tx_data,
   input wire tx_valid
);
   reg [7:0] rx_tab [0:127];
   reg [7:0] tx_seen [0:127];
   integer cnt;
   ////////////////////////////////////////////////////////////////
   // Odd slots 3, 5, 7 only; the data line outside its slot toggles, never holds
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         frame_pulse <= 1'b0;
         slot_strobe <= 1'b0;
         slot_index <= 7'h0;
         rx_data <= 8'h00;
      end else begin
         cnt <= (cnt == FRAME_CYC - 1) ? 0 : cnt + 1;
         frame_pulse <= (cnt == FRAME_CYC - 1);
         if (cnt == 10 || cnt == 12 || cnt == 14) begin
            slot_strobe <= 1'b1;
            slot_index <= 7'(cnt - 7);
            rx_data <= rx_tab[cnt - 7];
         end else begin
            slot_strobe <= 1'b0;
            rx_data <= ~rx_data;
         end
      end
   end
   // Index is held past the strobe, so the pulse still names its slot
   always @(posedge ref_clk) begin
      if (tx_valid) begin
         tx_seen[slot_index] <= tx_data;
      end
   end
endmodule // csh_sub_model

// File: dv/tb_top.sv
// Self-checking testbench for the change handler
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, frame_pulse, slot_strobe, tx_valid, timer_expired, irq_out;
   wire [6:0] slot_index;
   wire [7:0] rx_data, tx_data;
   logic [7:0] v, n;
   integer err_total = 0;
   integer samples_checked = 0;
   integer i;
   always #20 ref_clk = ~ref_clk;
   csh_top #(.TICK_CYC(10)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .frame_pulse(frame_pulse), .slot_strobe(slot_strobe),
      .slot_index(slot_index), .rx_data(rx_data), .tx_data(tx_data), .tx_valid(tx_valid),
      .timer_expired(timer_expired), .irq_out(irq_out));
   csh_sub_model #(.FRAME_CYC(200)) PAR (.ref_clk(ref_clk), .rst_n(rst_n),
      .frame_pulse(frame_pulse), .slot_strobe(slot_strobe), .slot_index(slot_index),
      .rx_data(rx_data), .tx_data(tx_data), .tx_valid(tx_valid));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest is seen low at a rising edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= 1'b1;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      avs_write <= 1'b0;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
      v = avs_readdata[7:0];
      avs_read <= 1'b0;
      chk(v, exp);
   endtask
   task automatic mw(input logic [7:0] loc, input logic [7:0] mac, input logic [7:0] d);
      wr(4'h7, d);
      wr(4'h6, loc);
      wr(4'h8, mac);
   endtask
   // Read back of one memory data field through the value register
   task automatic mr(input logic [7:0] loc, input logic [7:0] exp);
      wr(4'h6, loc);
      wr(4'h8, 8'hc8);
      rc(4'h7, exp);
   endtask
   task automatic frames(input integer k);
      repeat (k) @(posedge ref_clk iff frame_pulse === 1'b1);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Hang guard, well past the longest expected run
   initial begin
      #(40 * 30000);
      err_total++;
      complete_run;
   end
   // Main sequence
   initial begin
      PAR.rx_tab[3] = 8'hf3;
      PAR.rx_tab[5] = 8'h11;
      PAR.rx_tab[7] = 8'h44;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      rc(4'h3, 8'h01);
      rc(4'h4, 8'h00);
      rc(4'h0, 8'h00);
      rc(4'h1, 8'h00);
      rc(4'hf, 8'h00);
      $display("test 1 reset done");
      // even downstream carries value, codes set every slot pair
      mw(8'h83, 8'h78, 8'h00);
      mw(8'h82, 8'h78, 8'hf3);
      mw(8'h02, 8'h78, 8'h5a);
      mw(8'h85, 8'h7b, 8'h11);
      mw(8'h84, 8'h7b, 8'h11);
      mw(8'h04, 8'h7a, 8'h00);
      mw(8'h87, 8'h70, 8'h00);
      mw(8'h06, 8'h70, 8'h00);
      wr(4'h9, 8'h01);
      wr(4'h1, 8'h80);
      frames(2);
      chk(PAR.tx_seen[3], 8'h5a);
      rc(4'h0, 8'h00);
      PAR.rx_tab[3] = 8'h37;
      PAR.rx_tab[7] = 8'h55;
      frames(2);
      rc(4'h4, 8'h40);
      chk({7'h0, irq_out}, 8'h01);
      rc(4'h4, 8'h40);
      rc(4'h0, 8'h82);
      rc(4'h0, 8'h00);
      rc(4'h4, 8'h00);
      mr(8'h82, 8'h37);
      $display("test 2 command change done");
      wr(4'h5, 8'h40);
      PAR.rx_tab[3] = 8'h38;
      frames(2);
      chk({7'h0, irq_out}, 8'h00);
      rc(4'h4, 8'h40);
      wr(4'h2, 8'h00);
      rc(4'h4, 8'h40);
      wr(4'h2, 8'h10);
      rc(4'h4, 8'h00);
      rc(4'h0, 8'h00);
      wr(4'h5, 8'h00);
      $display("test 3 mask and flush done");
      frames(1);
      PAR.rx_tab[5] = 8'h22;
      frames(1);
      PAR.rx_tab[5] = 8'h11;
      frames(3);
      rc(4'h0, 8'h00);
      PAR.rx_tab[5] = 8'h22;
      frames(3);
      rc(4'h0, 8'h85);
      mr(8'h85, 8'h22);
      mr(8'h84, 8'h22);
      $display("test 4 signaling done");
      wr(4'h7, 8'h66);
      wr(4'h6, 8'h02);
      // Access write lands on a strobe so the slave must stall it
      @(posedge ref_clk iff PAR.cnt == 9);
      wr(4'h8, 8'h48);
      frames(2);
      chk(PAR.tx_seen[3], 8'h66);
      wr(4'h1, 8'h03);
      wr(4'h2, 8'h40);
      rc(4'h3, 8'h81);
      @(posedge ref_clk iff timer_expired === 1'b1);
      n = 8'h0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (timer_expired !== 1'b1);
      chk(n, 8'd40);
      wr(4'h1, 8'h03);
      rc(4'h3, 8'h01);
      wr(4'h2, 8'h40);
      wr(4'h9, 8'h00);
      rc(4'h3, 8'h01);
      wr(4'h9, 8'h01);
      $display("test 5 data write and timer done");
      for (i = 1; i <= 12; i++) begin
         frames(1);
         PAR.rx_tab[3] = 8'h40 + 8'(i);
      end
      frames(2);
      mr(8'h82, 8'h49);
      rc(4'h0, 8'h82);
      frames(2);
      mr(8'h82, 8'h4c);
      for (i = 0; i < `CSH_QDEPTH; i++) rc(4'h0, 8'h82);
      rc(4'h0, 8'h00);
      $display("test 6 queue overflow done");
      complete_run;
   end
endmodule // tb_top
